// [core/ccmd_consts.svh]
// Constants for the calibration command handler: offsets, fields, defaults.
// Functional notes
// - Keep an identification string of up to 100 characters and return it on query.
// - Identification string writes are refused unless the password was accepted first.
// - Password command with integer argument unlocks calibration commands when it matches.
// - Trim command takes selector 1 to 5 and a setting 0 to 255, loads that trim.
// - Trim query answers a plain integer value.
// - Voltage scale factor is stored and returned marked as exponent notation.
// - Current scale factor is stored and returned marked as exponent notation.
// - One full-scale value is stored for all external programming inputs.
// - Defaults command reloads every trim with its factory setting.
// - Calibration stop locks the protected commands until a new password.
// - Output start enables the output stage; output stop disables it.
// - Standard reset returns every setting to its factory default.
// - An error queue reports its entry count and each entry's type.
// - Newline, end-or-identify or CR plus newline ends a string and resets the path.
`ifndef CCMD_CONSTS_SVH
`define CCMD_CONSTS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define CCMD_OFS_CMD 8'h00
`define CCMD_OFS_ARG0 8'h04
`define CCMD_OFS_ARG1 8'h08
`define CCMD_OFS_RESULT 8'h0C
`define CCMD_OFS_STATUS 8'h10
`define CCMD_OFS_IDENT_CHAR 8'h14
`define CCMD_OFS_IDENT_INDEX 8'h18
`define CCMD_OFS_IDENT_DATA 8'h1C
`define CCMD_OFS_ERR_COUNT 8'h20
`define CCMD_OFS_ERR_POP 8'h24
`define CCMD_OFS_IRQ_STATUS 8'h28
`define CCMD_OFS_IRQ_MASK 8'h2C

// ****************************************************************
// Field positions and sizes
// ****************************************************************
`define CCMD_IRQ_CMD_DONE 0
`define CCMD_IRQ_ERROR 1
`define CCMD_IRQ_IDENT_DONE 2
`define CCMD_IRQ_BITS 3
`define CCMD_IDENT_EOI_BIT 8
`define CCMD_IDENT_MAX 7'h64
`define CCMD_TRIM_COUNT 5
`define CCMD_TRIM_SEL_MIN 32'h00000001
`define CCMD_TRIM_SEL_MAX 32'h00000005
`define CCMD_TRIM_SET_MAX 32'h000000FF
`define CCMD_ERR_DEPTH 8
`define CCMD_CHAR_NL 8'h0A
`define CCMD_CHAR_CR 8'h0D

// ****************************************************************
// Reset and factory values
// ****************************************************************
`define CCMD_TRIM_DEFAULT 8'h80
`define CCMD_SCALE_DEFAULT 32'h00000000
`define CCMD_CAL_PASSWORD 32'h000004D2

`endif

// [core/ccmd_pkg.sv]
// Types shared by the calibration command handler modules.
package ccmd_pkg;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b01,
    PH_ACK = 2'b10
  } ccmd_phase_type;

  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_PASSWORD = 4'h1,
    OP_TRIM_SET = 4'h2,
    OP_TRIM_QUERY = 4'h3,
    OP_SCALE_V_SET = 4'h4,
    OP_SCALE_V_QUERY = 4'h5,
    OP_SCALE_I_SET = 4'h6,
    OP_SCALE_I_QUERY = 4'h7,
    OP_SCALE_IN_SET = 4'h8,
    OP_SCALE_IN_QUERY = 4'h9,
    OP_CAL_DEFAULTS = 4'hA,
    OP_CAL_STOP = 4'hB,
    OP_OUT_START = 4'hC,
    OP_OUT_STOP = 4'hD,
    OP_STD_RESET = 4'hE,
    OP_OUT_QUERY = 4'hF
  } ccmd_opcode_type;

  typedef enum logic [3:0] {
    ERR_NONE = 4'h0,
    ERR_LOCKED = 4'h1,
    ERR_RANGE = 4'h2,
    ERR_PASSWORD = 4'h3,
    ERR_TOO_LONG = 4'h4
  } ccmd_err_code_type;

  typedef enum logic [1:0] {
    FMT_NONE = 2'h0,
    FMT_INTEGER = 2'h1,
    FMT_EXPONENT = 2'h2
  } ccmd_format_type;

  typedef struct packed {
    logic [3:0] opcode;
    ccmd_err_code_type code;
  } ccmd_err_entry_type;

  typedef logic [4:0][7:0] ccmd_trim_array_type;

endpackage

// [core/ccmd_sub_if.sv]
// Carrier between the handler core and its identification and error stores.
`timescale 1ns/1ps
interface ccmd_sub_if;
  logic identClear;
  logic identWrEn;
  logic [7:0] identWrData;
  logic [6:0] identRdIdx;
  logic [7:0] identRdData;
  logic [6:0] identLen;
  logic errPush;
  ccmd_pkg::ccmd_err_entry_type errPushData;
  logic errPop;
  ccmd_pkg::ccmd_err_entry_type errHead;
  logic [3:0] errCount;

  modport core (
    output identClear, identWrEn, identWrData, identRdIdx,
    input identRdData, identLen,
    output errPush, errPushData, errPop,
    input errHead, errCount
  );
  modport identSide (
    input identClear, identWrEn, identWrData, identRdIdx,
    output identRdData, identLen
  );
  modport errSide (
    input errPush, errPushData, errPop,
    output errHead, errCount
  );
endinterface

// [core/ccmd_ident_store.sv]
// Identification string memory, up to 100 characters.
`timescale 1ns/1ps
`include "ccmd_consts.svh"
module ccmd_ident_store (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Core side
  ccmd_sub_if.identSide sub
);

  typedef struct packed {
    logic [99:0][7:0] mem;
    logic [6:0] len;
  } ccmd_ident_state_type;

  ccmd_ident_state_type state;
  ccmd_ident_state_type next_state;

  always_comb
  begin
    next_state = state;
    if (sub.identClear)
    begin
      next_state.len = 7'h00;
    end
    else if (sub.identWrEn && (state.len < `CCMD_IDENT_MAX))
    begin
      next_state.mem[state.len] = sub.identWrData;
      next_state.len = state.len + 7'h01;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state.len <= 7'h00;
      state.mem <= state.mem;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Indices past the stored length read as zero
  assign sub.identRdData = (sub.identRdIdx < state.len) ? state.mem[sub.identRdIdx] : 8'h00;
  assign sub.identLen = state.len;

endmodule

// [core/ccmd_err_queue.sv]
// Error queue of eight entries; a push into a full queue is dropped unless a pop is taken in the same cycle.
`timescale 1ns/1ps
`include "ccmd_consts.svh"
module ccmd_err_queue (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Core side
  ccmd_sub_if.errSide sub
);

  typedef struct packed {
    logic [7:0][7:0] mem;
    logic [2:0] wrPtr;
    logic [2:0] rdPtr;
    logic [3:0] count;
  } ccmd_errq_state_type;

  ccmd_errq_state_type state;
  ccmd_errq_state_type next_state;
  logic doPush;
  logic doPop;

  always_comb
  begin
    next_state = state;
    doPop = sub.errPop && (state.count != 4'h0);
    doPush = sub.errPush && ((state.count != 4'h8) || doPop);
    if (doPush)
    begin
      next_state.mem[state.wrPtr] = sub.errPushData;
      next_state.wrPtr = state.wrPtr + 3'h1;
    end
    if (doPop)
    begin
      next_state.rdPtr = state.rdPtr + 3'h1;
    end
    if (doPush && !doPop)
    begin
      next_state.count = state.count + 4'h1;
    end
    else if (doPop && !doPush)
    begin
      next_state.count = state.count - 4'h1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state.mem <= '0;
      state.wrPtr <= 3'h0;
      state.rdPtr <= 3'h0;
      state.count <= 4'h0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign sub.errHead = (state.count != 4'h0) ? ccmd_pkg::ccmd_err_entry_type'(state.mem[state.rdPtr])
                                             : ccmd_pkg::ccmd_err_entry_type'(8'h00);
  assign sub.errCount = state.count;

endmodule

// [core/ccmd_top.sv]
// Calibration command handler: Avalon-MM register slave and command executor.
`timescale 1ns/1ps
`include "ccmd_consts.svh"
module ccmd_top (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Interrupt
  output logic irq,
  // Calibration outputs
  output ccmd_pkg::ccmd_trim_array_type trimPot,
  output logic [31:0] scaleVoltage,
  output logic [31:0] scaleCurrent,
  output logic [31:0] scaleInput,
  output logic calUnlocked,
  output logic outputStageEnable
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    ccmd_pkg::ccmd_phase_type phase;
    logic waitReq;
    logic [31:0] rdData;
    logic unlocked;
    logic identActive;
    logic outEnable;
    ccmd_pkg::ccmd_trim_array_type trim;
    logic [31:0] scaleV;
    logic [31:0] scaleI;
    logic [31:0] scaleIn;
    logic [31:0] arg0;
    logic [31:0] arg1;
    logic [31:0] result;
    ccmd_pkg::ccmd_format_type resultFmt;
    logic [2:0] irqStatus;
    logic [2:0] irqMask;
    logic [6:0] identIdx;
    logic irqOut;
  } ccmd_top_state_type;

  ccmd_top_state_type state;
  ccmd_top_state_type next_state;
  ccmd_sub_if sub ();

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] mergeBytes(input logic [31:0] oldVal,
                                             input logic [31:0] newVal,
                                             input logic [3:0] be);
    logic [31:0] res;
    res = oldVal;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        res[i*8 +: 8] = newVal[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Commands that need the password first
  function automatic logic isProtected(input ccmd_pkg::ccmd_opcode_type op);
    return (op == ccmd_pkg::OP_TRIM_SET) || (op == ccmd_pkg::OP_SCALE_V_SET)
        || (op == ccmd_pkg::OP_SCALE_I_SET) || (op == ccmd_pkg::OP_SCALE_IN_SET)
        || (op == ccmd_pkg::OP_CAL_DEFAULTS);
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  logic take;
  logic doWrite;
  logic doRead;
  logic [7:0] wordAddr;
  logic [2:0] events;
  ccmd_pkg::ccmd_opcode_type op;
  ccmd_pkg::ccmd_err_code_type err;
  logic [7:0] ch;
  logic isTerm;
  logic [2:0] trimSel;

  always_comb
  begin
    next_state = state;
    events = 3'h0;
    err = ccmd_pkg::ERR_NONE;
    op = ccmd_pkg::ccmd_opcode_type'(avs_writedata[3:0]);
    ch = avs_writedata[7:0];
    isTerm = (ch == `CCMD_CHAR_NL) || avs_writedata[`CCMD_IDENT_EOI_BIT];
    trimSel = 3'(state.arg0[2:0] - 3'h1);
    wordAddr = {avs_address[7:2], 2'b00};
    take = (state.phase == ccmd_pkg::PH_IDLE) && (avs_read || avs_write);
    doWrite = take && avs_write;
    doRead = take && avs_read;
    sub.identClear = 1'b0;
    sub.identWrEn = 1'b0;
    sub.identWrData = ch;
    sub.identRdIdx = state.identIdx;
    sub.errPush = 1'b0;
    sub.errPushData = '0;
    sub.errPop = 1'b0;

    // Bus handshake: one idle cycle with waitrequest high, then one ack cycle
    if (take)
    begin
      next_state.phase = ccmd_pkg::PH_ACK;
      next_state.waitReq = 1'b0;
    end
    else
    begin
      next_state.phase = ccmd_pkg::PH_IDLE;
      next_state.waitReq = 1'b1;
    end

    if (doWrite)
    begin
      unique case (wordAddr)
        `CCMD_OFS_CMD:
        begin
          if (avs_byteenable[0])
          begin
            events[`CCMD_IRQ_CMD_DONE] = 1'b1;
            if (isProtected(op) && !state.unlocked)
            begin
              err = ccmd_pkg::ERR_LOCKED;
            end
            else
            begin
              unique case (op)
                ccmd_pkg::OP_PASSWORD:
                begin
                  if (state.arg0 == `CCMD_CAL_PASSWORD)
                  begin
                    next_state.unlocked = 1'b1;
                  end
                  else
                  begin
                    err = ccmd_pkg::ERR_PASSWORD;
                  end
                end
                ccmd_pkg::OP_TRIM_SET:
                begin
                  if ((state.arg0 < `CCMD_TRIM_SEL_MIN) || (state.arg0 > `CCMD_TRIM_SEL_MAX)
                      || (state.arg1 > `CCMD_TRIM_SET_MAX))
                  begin
                    err = ccmd_pkg::ERR_RANGE;
                  end
                  else
                  begin
                    next_state.trim[trimSel] = state.arg1[7:0];
                  end
                end
                ccmd_pkg::OP_TRIM_QUERY:
                begin
                  if ((state.arg0 < `CCMD_TRIM_SEL_MIN) || (state.arg0 > `CCMD_TRIM_SEL_MAX))
                  begin
                    err = ccmd_pkg::ERR_RANGE;
                  end
                  else
                  begin
                    next_state.result = {24'h000000, state.trim[trimSel]};
                    next_state.resultFmt = ccmd_pkg::FMT_INTEGER;
                  end
                end
                ccmd_pkg::OP_SCALE_V_SET:
                begin
                  next_state.scaleV = state.arg0;
                end
                ccmd_pkg::OP_SCALE_V_QUERY:
                begin
                  next_state.result = state.scaleV;
                  next_state.resultFmt = ccmd_pkg::FMT_EXPONENT;
                end
                ccmd_pkg::OP_SCALE_I_SET:
                begin
                  next_state.scaleI = state.arg0;
                end
                ccmd_pkg::OP_SCALE_I_QUERY:
                begin
                  next_state.result = state.scaleI;
                  next_state.resultFmt = ccmd_pkg::FMT_EXPONENT;
                end
                ccmd_pkg::OP_SCALE_IN_SET:
                begin
                  next_state.scaleIn = state.arg0;
                end
                ccmd_pkg::OP_SCALE_IN_QUERY:
                begin
                  next_state.result = state.scaleIn;
                  next_state.resultFmt = ccmd_pkg::FMT_EXPONENT;
                end
                ccmd_pkg::OP_CAL_DEFAULTS:
                begin
                  next_state.trim = {`CCMD_TRIM_COUNT{`CCMD_TRIM_DEFAULT}};
                end
                ccmd_pkg::OP_CAL_STOP:
                begin
                  next_state.unlocked = 1'b0;
                  next_state.identActive = 1'b0;
                end
                ccmd_pkg::OP_OUT_START:
                begin
                  next_state.outEnable = 1'b1;
                end
                ccmd_pkg::OP_OUT_STOP:
                begin
                  next_state.outEnable = 1'b0;
                end
                ccmd_pkg::OP_STD_RESET:
                begin
                  // Identification string is kept: it names the unit, not a setting
                  next_state.trim = {`CCMD_TRIM_COUNT{`CCMD_TRIM_DEFAULT}};
                  next_state.scaleV = `CCMD_SCALE_DEFAULT;
                  next_state.scaleI = `CCMD_SCALE_DEFAULT;
                  next_state.scaleIn = `CCMD_SCALE_DEFAULT;
                  next_state.outEnable = 1'b0;
                  next_state.unlocked = 1'b0;
                  next_state.identActive = 1'b0;
                end
                ccmd_pkg::OP_OUT_QUERY:
                begin
                  next_state.result = {31'h00000000, state.outEnable};
                  next_state.resultFmt = ccmd_pkg::FMT_INTEGER;
                end
                ccmd_pkg::OP_NOP:
                begin
                  next_state.result = state.result;
                end
              endcase
            end
          end
        end
        `CCMD_OFS_ARG0:
        begin
          next_state.arg0 = mergeBytes(state.arg0, avs_writedata, avs_byteenable);
        end
        `CCMD_OFS_ARG1:
        begin
          next_state.arg1 = mergeBytes(state.arg1, avs_writedata, avs_byteenable);
        end
        `CCMD_OFS_IDENT_CHAR:
        begin
          if (avs_byteenable[0])
          begin
            if (isTerm)
            begin
              // Terminator returns the path to root and closes the string
              if (state.identActive)
              begin
                events[`CCMD_IRQ_IDENT_DONE] = 1'b1;
              end
              next_state.identActive = 1'b0;
            end
            else if (ch == `CCMD_CHAR_CR)
            begin
              next_state.identActive = state.identActive;
            end
            else if (!state.unlocked)
            begin
              err = ccmd_pkg::ERR_LOCKED;
            end
            else
            begin
              next_state.identActive = 1'b1;
              sub.identClear = !state.identActive;
              sub.identWrEn = state.identActive;
              if (state.identActive && (sub.identLen >= `CCMD_IDENT_MAX))
              begin
                err = ccmd_pkg::ERR_TOO_LONG;
              end
            end
          end
        end
        `CCMD_OFS_IDENT_INDEX:
        begin
          next_state.identIdx = 7'(mergeBytes({25'h0000000, state.identIdx}, avs_writedata,
                                              avs_byteenable));
        end
        `CCMD_OFS_IRQ_STATUS:
        begin
          next_state.irqStatus = state.irqStatus & ~avs_writedata[2:0];
        end
        `CCMD_OFS_IRQ_MASK:
        begin
          next_state.irqMask = 3'(mergeBytes({29'h00000000, state.irqMask}, avs_writedata,
                                             avs_byteenable));
        end
        default: next_state.rdData = state.rdData;
      endcase
    end

    // First character of a new string only clears the store; it is not itself stored
    if (doWrite && (wordAddr == `CCMD_OFS_IDENT_CHAR) && sub.identClear)
    begin
      sub.identWrEn = 1'b0;
    end

    if (err != ccmd_pkg::ERR_NONE)
    begin
      sub.errPush = 1'b1;
      sub.errPushData = '{opcode: avs_writedata[3:0], code: err};
      events[`CCMD_IRQ_ERROR] = 1'b1;
    end

    if (doRead)
    begin
      unique case (wordAddr)
        `CCMD_OFS_ARG0: next_state.rdData = state.arg0;
        `CCMD_OFS_ARG1: next_state.rdData = state.arg1;
        `CCMD_OFS_RESULT: next_state.rdData = state.result;
        `CCMD_OFS_STATUS: next_state.rdData = {26'h0000000, state.resultFmt, 1'b0,
                                               state.identActive, state.outEnable,
                                               state.unlocked};
        `CCMD_OFS_IDENT_INDEX: next_state.rdData = {25'h0000000, state.identIdx};
        `CCMD_OFS_IDENT_DATA: next_state.rdData = {17'h00000, sub.identLen, sub.identRdData};
        `CCMD_OFS_ERR_COUNT: next_state.rdData = {28'h0000000, sub.errCount};
        `CCMD_OFS_ERR_POP:
        begin
          next_state.rdData = {24'h000000, sub.errHead};
          sub.errPop = 1'b1;
        end
        `CCMD_OFS_IRQ_STATUS: next_state.rdData = {29'h00000000, state.irqStatus};
        `CCMD_OFS_IRQ_MASK: next_state.rdData = {29'h00000000, state.irqMask};
        default: next_state.rdData = 32'h00000000;
      endcase
    end

    // Set wins over a simultaneous write-one clear
    next_state.irqStatus = next_state.irqStatus | events;
    next_state.irqOut = |(next_state.irqStatus & next_state.irqMask);
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state.phase <= ccmd_pkg::PH_IDLE;
      state.waitReq <= 1'b1;
      state.rdData <= 32'h00000000;
      state.unlocked <= 1'b0;
      state.identActive <= 1'b0;
      state.outEnable <= 1'b0;
      state.trim <= {`CCMD_TRIM_COUNT{`CCMD_TRIM_DEFAULT}};
      state.scaleV <= `CCMD_SCALE_DEFAULT;
      state.scaleI <= `CCMD_SCALE_DEFAULT;
      state.scaleIn <= `CCMD_SCALE_DEFAULT;
      state.arg0 <= 32'h00000000;
      state.arg1 <= 32'h00000000;
      state.result <= 32'h00000000;
      state.resultFmt <= ccmd_pkg::FMT_NONE;
      state.irqStatus <= 3'h0;
      state.irqMask <= 3'h0;
      state.identIdx <= 7'h00;
      state.irqOut <= 1'b0;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ****************************************************************
  // Stores
  // ****************************************************************
  ccmd_ident_store u_ident (
    .clk(clk),
    .sys_rst(sys_rst),
    .sub(sub.identSide)
  );

  ccmd_err_queue u_errq (
    .clk(clk),
    .sys_rst(sys_rst),
    .sub(sub.errSide)
  );

  assign avs_readdata = state.rdData;
  assign avs_waitrequest = state.waitReq;
  assign irq = state.irqOut;
  assign trimPot = state.trim;
  assign scaleVoltage = state.scaleV;
  assign scaleCurrent = state.scaleI;
  assign scaleInput = state.scaleIn;
  assign calUnlocked = state.unlocked;
  assign outputStageEnable = state.outEnable;

endmodule

// [dv/ccmd_monitor.sv]
// Port checker for the calibration command handler.
`timescale 1ns/1ps
module ccmd_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Bus
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  // Outputs
  input wire ccmd_pkg::ccmd_trim_array_type trimPot,
  input wire logic [31:0] scaleVoltage,
  input wire logic calUnlocked,
  input wire logic outputStageEnable
);
  logic cmdWr;
  logic [3:0] op;
  // Only the taking edge counts, so a held request is not seen twice
  assign cmdWr = avs_write && avs_waitrequest && avs_address[7:2] == 6'h00 && avs_byteenable[0];
  assign op = avs_writedata[3:0];
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_ack_next: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered");
  a_ack_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("ack held too long");
  a_ack_cause: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("ack without request");
  a_unlock_cause: assert property ($rose(calUnlocked) |-> $past(op) == 4'h1 || $past(op, 2) == 4'h1)
    else $error("unlock without password");
  a_lock_stop: assert property (cmdWr && op == 4'hB |-> ##[1:3] !calUnlocked)
    else $error("stop kept unlock");
  a_trim_locked: assert property (!calUnlocked |=> $stable(trimPot) || trimPot == {5{8'h80}})
    else $error("trim moved while locked");
  a_scale_locked: assert property (!calUnlocked |=> $stable(scaleVoltage) || scaleVoltage == 32'h0)
    else $error("scale moved while locked");
  a_out_start: assert property (cmdWr && op == 4'hC |-> ##[1:3] outputStageEnable)
    else $error("output not started");
  a_out_stop: assert property (cmdWr && op == 4'hD |-> ##[1:3] !outputStageEnable)
    else $error("output not stopped");
  a_trim_defaults: assert property (cmdWr && op == 4'hA && calUnlocked |-> ##[1:3] trimPot == {5{8'h80}})
    else $error("defaults not loaded");
  a_std_reset: assert property (cmdWr && op == 4'hE |-> ##[1:3] !outputStageEnable && !calUnlocked)
    else $error("reset kept state");
endmodule

// [dv/ccmd_host_model.sv]
// Host controller model acting as Avalon-MM master of the handler.
`timescale 1ns/1ps
module ccmd_host_model (
  // Clock
  input wire logic clk,
  // Avalon-MM master
  output logic [7:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  initial
  begin
    {avs_address, avs_writedata} = 40'h0000000000;
    {avs_read, avs_write} = 2'b00;
  end
  task automatic xfer(input logic rnw, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= rnw;
    avs_write <= !rnw;
    @(posedge clk);
    while (avs_waitrequest) @(posedge clk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // Released data must not keep showing the last word
    avs_writedata <= ~d;
    @(posedge clk);
  endtask
  // Only called after the password was accepted
  task automatic ident(input logic [7:0] c0, input logic [7:0] c1, input logic [8:0] term);
    logic [31:0] q;
    xfer(1'b0, 8'h14, 32'h53, q);
    xfer(1'b0, 8'h14, {24'h0, c0}, q);
    xfer(1'b0, 8'h14, {24'h0, c1}, q);
    xfer(1'b0, 8'h14, {23'h0, term}, q);
  endtask
endmodule

// [dv/testbench.sv]
// Self-checking bench for the calibration command handler.
`timescale 1ns/1ps
`define CK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; $display("BAD %0t got %h want %h", $time, (a), (b)); end end
module testbench;
  logic clk;
  logic sys_rst;
  logic [7:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest, irq, calUnlocked, outputStageEnable;
  logic [31:0] avs_writedata, avs_readdata, rv, scaleVoltage, scaleCurrent, scaleInput;
  ccmd_pkg::ccmd_trim_array_type trimPot;
  int n_mismatch = 0;
  int compares = 0;
  int cyc = 0;
  ccmd_top DUT (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
    .trimPot(trimPot), .scaleVoltage(scaleVoltage), .scaleCurrent(scaleCurrent),
    .scaleInput(scaleInput), .calUnlocked(calUnlocked), .outputStageEnable(outputStageEnable));
  ccmd_host_model host (.clk(clk), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  // ****
  // Bus helpers
  // ****
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b0, a, d, rv);
  endtask
  task automatic rd(input logic [7:0] a);
    host.xfer(1'b1, a, 32'h0, rv);
  endtask
  task automatic cmd(input logic [3:0] op, input logic [31:0] a0, input logic [31:0] a1);
    wr(8'h04, a0);
    wr(8'h08, a1);
    wr(8'h00, {28'h0, op});
  endtask
  task automatic pop(input logic [31:0] exp);
    rd(8'h24);
    `CK(rv, exp)
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_locked;
    cmd(4'h2, 32'h1, 32'h7);
    `CK(trimPot[0], 8'h80)
    wr(8'h14, 32'h41);
    rd(8'h20);
    `CK(rv, 32'h2)
    pop(32'h21);
    pop(32'h11);
    wr(8'h2C, 32'h2);
    `CK(irq, 1'b1)
    wr(8'h28, 32'h7);
    `CK(irq, 1'b0)
  endtask
  task automatic t_pw_trim;
    cmd(4'h1, 32'h4D3, 32'h0);
    `CK(calUnlocked, 1'b0)
    pop(32'h13);
    cmd(4'h1, 32'h4D2, 32'h0);
    `CK(calUnlocked, 1'b1)
    cmd(4'h2, 32'h5, 32'hFF);
    cmd(4'h2, 32'h1, 32'h0);
    cmd(4'h2, 32'h6, 32'h1);
    cmd(4'h2, 32'h1, 32'h100);
    `CK(trimPot[4], 8'hFF)
    `CK(trimPot[0], 8'h00)
    pop(32'h22);
    pop(32'h22);
    cmd(4'h3, 32'h5, 32'h0);
    rd(8'h0C);
    `CK(rv, 32'hFF)
    rd(8'h10);
    `CK(rv[5:4], 2'h1)
  endtask
  task automatic t_scale_ident;
    for (int i = 0; i < 3; i++) cmd(4'h4 + 4'(2 * i), 32'h100 + i, 32'h0);
    `CK(scaleVoltage, 32'h100)
    `CK(scaleCurrent, 32'h101)
    `CK(scaleInput, 32'h102)
    for (int i = 0; i < 3; i++)
    begin
      cmd(4'h5 + 4'(2 * i), 32'h0, 32'h0);
      rd(8'h0C);
      `CK(rv, 32'h100 + i)
    end
    rd(8'h10);
    `CK(rv[5:4], 2'h2)
    host.ident(8'h41, 8'h42, 9'h00A);
    wr(8'h18, 32'h0);
    rd(8'h1C);
    `CK(rv, 32'h241)
    host.ident(8'h43, 8'h0D, 9'h100);
    rd(8'h1C);
    `CK(rv, 32'h143)
  endtask
  task automatic t_stop_out;
    cmd(4'hA, 32'h0, 32'h0);
    `CK(trimPot[4], 8'h80)
    cmd(4'hB, 32'h0, 32'h0);
    `CK(calUnlocked, 1'b0)
    cmd(4'h2, 32'h2, 32'h9);
    `CK(trimPot[1], 8'h80)
    cmd(4'hC, 32'h0, 32'h0);
    `CK(outputStageEnable, 1'b1)
    cmd(4'hF, 32'h0, 32'h0);
    rd(8'h0C);
    `CK(rv, 32'h1)
    cmd(4'hD, 32'h0, 32'h0);
    `CK(outputStageEnable, 1'b0)
    cmd(4'hC, 32'h0, 32'h0);
    cmd(4'h1, 32'h4D2, 32'h0);
    cmd(4'hE, 32'h0, 32'h0);
    `CK(outputStageEnable, 1'b0)
    `CK(scaleVoltage, 32'h0)
    `CK(calUnlocked, 1'b0)
    rd(8'h20);
    `CK(rv, 32'h1)
    rd(8'hFC);
    `CK(rv, 32'h0)
  endtask
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Ceiling well above the few hundred cycles the scenarios need
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end
  initial
  begin
    sys_rst = 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_locked();
    t_pw_trim();
    t_scale_ident();
    t_stop_out();
    end_of_test();
  end
endmodule
bind ccmd_top ccmd_monitor mon (.clk(clk), .sys_rst(sys_rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest), .trimPot(trimPot),
  .scaleVoltage(scaleVoltage), .calUnlocked(calUnlocked), .outputStageEnable(outputStageEnable));
